/* drw_dma_ctrl.v */
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`include "drw_map.vh"

module drw_dma_ctrl
(
	// Clock and reset
	input wire mclk,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Request pins and internal request sources
	input wire ch0_request_n,
	input wire ch1_request_n,
	input wire serial0TxReady,
	input wire serial1TxReady,
	input wire serial0RxReady,
	input wire serial1RxReady,
	input wire ch1TransferEnd,
	input wire cpuCycleEnd,
	// Wait and channel 1 configuration
	output wire [1:0] memoryWaitCount,
	output wire [1:0] ioWaitCount,
	output wire ch1SenseEdge,
	output wire [1:0] ch1DirectionMode,
	output wire timerPinOut,
	output wire ch1Request,
	// Channel 0 bus activity
	output wire dmaBusOwn,
	output wire dmaReadCycle,
	output wire dmaWriteCycle,
	output wire dmaIoAccess,
	output wire dmaWaitState,
	output reg ch0_last_transfer_n,
	output reg ch0DonePulse
);

	// ----------------------------------------
	// Constants and helpers
	// ----------------------------------------
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_START = 6'h02;
	localparam [5:0] ST_WAITREQ = 6'h04;
	localparam [5:0] ST_READ = 6'h08;
	localparam [5:0] ST_WRITE = 6'h10;
	localparam [5:0] ST_CPU = 6'h20;
	localparam integer START_N = (`DRW_MCYCLE_NS + `DRW_CLK_NS - 1) / `DRW_CLK_NS;
	localparam [2:0] START_CLKS = START_N[2:0];
	localparam [2:0] BASE_LEN = `DRW_BASE_STATES;
	localparam [2:0] IO_WAIT = `DRW_IO_AUTO_WAIT;

	// Length of one bus cycle in clocks: T1, T2, waits, T3.
	function [2:0] cycleLen;
		input [1:0] waits;
		input isIo;
		begin
			cycleLen = BASE_LEN + {1'b0, waits} + (isIo ? IO_WAIT : 3'd0);
		end
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] waitCtrl_q;
	reg [7:0] route_q;
	reg [7:0] mode_q;
	reg [15:0] count_q;
	reg run_q;
	reg [5:0] state_q;
	reg [5:0] state_d;
	reg [2:0] phase_q;
	reg [2:0] phase_d;
	reg contReq_q;
	reg ch0Sync1_q;
	reg ch0Sync2_q;
	reg ch0Prev_q;
	reg ch1Sync1_q;
	reg ch1Sync2_q;
	reg edgeSeen_q;
	reg altFf_q;
	reg ch1Routed;
	wire [9:0] regIdx;
	wire hit;
	wire wrEn;
	wire stRead;
	wire stWrite;
	wire memToMem;
	wire srcIo;
	wire dstIo;
	wire curIo;
	wire [2:0] curLen;
	wire lastPhase;
	wire samplePoint;
	wire altEn;
	wire ch0PinActive;
	wire ch0ReqActive;
	wire edgeMode;
	wire ch0Fall;
	wire consumeEdge;
	wire xferEnd;
	wire finalByte;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign regIdx = paddr[11:2];
	assign hit = (regIdx == `DRW_IDX_ROUTE) || (regIdx == `DRW_IDX_MODE) ||
		(regIdx == `DRW_IDX_WAIT) || (regIdx == `DRW_IDX_COUNT) ||
		(regIdx == `DRW_IDX_STATE);
	// Zero wait states keep the CPU-side model simple; every access ends in one access cycle.
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wrEn = psel & penable & pwrite & hit & pstrb[0];

	always @*
	begin
		prdata = 32'h0000_0000;
		if (psel & ~pwrite)
		begin
			case (regIdx)
				`DRW_IDX_WAIT: prdata[7:0] = waitCtrl_q;
				`DRW_IDX_ROUTE: prdata[7:0] = {route_q[7], altFf_q, route_q[5:0]};
				`DRW_IDX_MODE: prdata[7:0] = mode_q;
				`DRW_IDX_COUNT: prdata[15:0] = count_q;
				`DRW_IDX_STATE: prdata[5:0] = {ch0_last_transfer_n, ch1Request,
					dmaBusOwn, 1'b0, 1'b1, run_q};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			waitCtrl_q <= `DRW_WAIT_RESET;
			mode_q <= `DRW_MODE_RESET;
			count_q <= `DRW_COUNT_RESET;
		end
		else
		begin
			if (wrEn && (regIdx == `DRW_IDX_WAIT))
				waitCtrl_q <= pwdata[7:0];
			if (wrEn && (regIdx == `DRW_IDX_MODE))
				mode_q <= pwdata[7:0] & `DRW_MODE_MASK;
			if (stWrite && lastPhase)
				count_q <= count_q - 16'h0001;
			else if (psel & penable & pwrite & (regIdx == `DRW_IDX_COUNT))
			begin
				if (pstrb[0])
					count_q[7:0] <= pwdata[7:0];
				if (pstrb[1])
					count_q[15:8] <= pwdata[15:8];
			end
		end
	end

	// ----------------------------------------
	// Configuration outputs
	// ----------------------------------------
	// memory wait count
	assign memoryWaitCount = waitCtrl_q[`DRW_W_MEMWAIT_HI:`DRW_W_MEMWAIT_LO];
	assign ioWaitCount = waitCtrl_q[`DRW_W_IOWAIT_HI:`DRW_W_IOWAIT_LO];
	assign ch1SenseEdge = waitCtrl_q[`DRW_W_SENSE1];
	assign edgeMode = waitCtrl_q[`DRW_W_SENSE0];
	assign ch1DirectionMode = waitCtrl_q[`DRW_W_DIR_HI:`DRW_W_DIR_LO];
	assign timerPinOut = route_q[`DRW_R_PIN_TIMER];
	assign altEn = route_q[`DRW_R_ALT_EN];

	// ----------------------------------------
	// Request pin synchronisers
	// ----------------------------------------
	always @(posedge mclk)
	begin
		if (rst)
		begin
			ch0Sync1_q <= 1'b1;
			ch0Sync2_q <= 1'b1;
			ch0Prev_q <= 1'b1;
			ch1Sync1_q <= 1'b1;
			ch1Sync2_q <= 1'b1;
		end
		else
		begin
			ch0Sync1_q <= ch0_request_n;
			ch0Sync2_q <= ch0Sync1_q;
			ch0Prev_q <= ch0Sync2_q;
			ch1Sync1_q <= ch1_request_n;
			ch1Sync2_q <= ch1Sync1_q;
		end
	end

	assign ch0PinActive = ~ch0Sync2_q;
	assign ch0ReqActive = ch0PinActive & ~(altEn & altFf_q);
	assign ch0Fall = ch0Prev_q & ~ch0Sync2_q & ~(altEn & altFf_q);

	// ----------------------------------------
	// Alternate flip-flop and route register
	// ----------------------------------------
	always @(posedge mclk)
	begin
		if (rst)
		begin
			route_q <= `DRW_ROUTE_RESET;
			altFf_q <= 1'b0;
		end
		else
		begin
			if (wrEn && (regIdx == `DRW_IDX_ROUTE))
				route_q <= pwdata[7:0] & `DRW_ROUTE_MASK;
			if (altEn && ch0DonePulse && ch1TransferEnd)
				altFf_q <= ~altFf_q;
			else if (altEn && ch0DonePulse)
				altFf_q <= 1'b1;
			else if (altEn && ch1TransferEnd)
				altFf_q <= 1'b0;
			else if (wrEn && (regIdx == `DRW_IDX_ROUTE))
				altFf_q <= pwdata[`DRW_R_ALT_FF];
		end
	end

	// ----------------------------------------
	// Channel 1 request routing
	// ----------------------------------------
	always @*
	begin
		ch1Routed = 1'b0;
		case (route_q[`DRW_R_ROUTE_HI:`DRW_R_ROUTE_LO])
			`DRW_RT_OWN_PIN: ch1Routed = ~ch1Sync2_q & ~timerPinOut;
			`DRW_RT_SERIAL0: ch1Routed = ch1DirectionMode[1] ? serial0RxReady : serial0TxReady;
			`DRW_RT_SERIAL1: ch1Routed = ch1DirectionMode[1] ? serial1RxReady : serial1TxReady;
			`DRW_RT_CH0_PIN: ch1Routed = ch0PinActive;
			default: ch1Routed = 1'b0;
		endcase
	end

	assign ch1Request = altEn ? (altFf_q & ch0PinActive) : ch1Routed;

	// ----------------------------------------
	// Channel 0 sequencer
	// ----------------------------------------
	assign stRead = state_q[3];
	assign stWrite = state_q[4];
	assign srcIo = mode_q[`DRW_M_SRC_HI:`DRW_M_SRC_LO] == 2'b11;
	assign dstIo = mode_q[`DRW_M_DEST_HI:`DRW_M_DEST_LO] == 2'b11;
	assign memToMem = ~srcIo & ~dstIo;
	assign curIo = stRead ? srcIo : dstIo;
	assign curLen = cycleLen(curIo ? ioWaitCount : memoryWaitCount, curIo);
	assign lastPhase = phase_q == (curLen - 3'd1);
	assign samplePoint = stWrite && (phase_q == (curLen - 3'd2));
	assign xferEnd = stWrite & lastPhase;
	assign finalByte = count_q == 16'h0001;
	assign consumeEdge = edgeMode && ((state_q == ST_WAITREQ && run_q) || samplePoint);

	assign dmaBusOwn = stRead | stWrite;
	assign dmaReadCycle = stRead;
	assign dmaWriteCycle = stWrite;
	assign dmaIoAccess = (stRead | stWrite) & curIo;
	assign dmaWaitState = (stRead | stWrite) && (phase_q >= 3'd2) && ~lastPhase;

	always @*
	begin
		state_d = state_q;
		phase_d = phase_q + 3'd1;
		case (state_q)
			ST_IDLE:
			begin
				phase_d = 3'd0;
				if (run_q)
					state_d = ST_START;
			end
			ST_START:
			begin
				if (phase_q == START_CLKS - 3'd1)
				begin
					phase_d = 3'd0;
					state_d = memToMem ? ST_READ : ST_WAITREQ;
				end
			end
			ST_WAITREQ:
			begin
				phase_d = 3'd0;
				if (!run_q)
					state_d = ST_IDLE;
				else if (edgeMode ? edgeSeen_q : ch0ReqActive)
					state_d = ST_READ;
			end
			ST_READ:
			begin
				if (lastPhase)
				begin
					phase_d = 3'd0;
					state_d = ST_WRITE;
				end
			end
			ST_WRITE:
			begin
				if (lastPhase)
				begin
					phase_d = 3'd0;
					if (finalByte || !run_q)
						state_d = ST_IDLE;
					else if (memToMem)
						state_d = mode_q[`DRW_M_TIMING] ? ST_READ : ST_CPU;
					else
						state_d = contReq_q ? ST_READ : ST_WAITREQ;
				end
			end
			ST_CPU:
			begin
				phase_d = 3'd0;
				if (!run_q)
					state_d = ST_IDLE;
				else if (cpuCycleEnd)
					state_d = ST_READ;
			end
			default:
			begin
				phase_d = 3'd0;
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			phase_q <= 3'd0;
			run_q <= 1'b0;
			contReq_q <= 1'b0;
			edgeSeen_q <= 1'b0;
			ch0_last_transfer_n <= 1'b1;
			ch0DonePulse <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			phase_q <= phase_d;
			ch0DonePulse <= xferEnd & finalByte;
			if (wrEn && (regIdx == `DRW_IDX_STATE) && !pwdata[`DRW_S_GUARD_N])
				run_q <= pwdata[`DRW_S_RUN];
			else if (xferEnd && finalByte)
				run_q <= 1'b0;
			if (samplePoint)
				contReq_q <= edgeMode ? (edgeSeen_q | ch0Fall) : ch0ReqActive;
			// A new edge landing while the old one is used is kept, not lost.
			// Edges seen under level sense are dropped, so no stale edge starts a transfer.
			if (ch0Fall && edgeMode)
				edgeSeen_q <= 1'b1;
			else if (consumeEdge || !edgeMode)
				edgeSeen_q <= 1'b0;
			ch0_last_transfer_n <= ~(state_d == ST_WRITE && finalByte && !memToMem);
		end
	end

endmodule // drw_dma_ctrl

/* drw_map.vh */
`ifndef DRW_MAP_VH
`define DRW_MAP_VH
// ----------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------
`define DRW_IDX_ROUTE 10'h02d
`define DRW_IDX_MODE 10'h031
`define DRW_IDX_WAIT 10'h032
`define DRW_IDX_COUNT 10'h040
`define DRW_IDX_STATE 10'h041
// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define DRW_WAIT_RESET 8'hf0
`define DRW_ROUTE_RESET 8'h00
`define DRW_ROUTE_MASK 8'hcf
`define DRW_MODE_RESET 8'h00
`define DRW_MODE_MASK 8'h3e
`define DRW_COUNT_RESET 16'h0000
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DRW_W_MEMWAIT_HI 7
`define DRW_W_MEMWAIT_LO 6
`define DRW_W_IOWAIT_HI 5
`define DRW_W_IOWAIT_LO 4
`define DRW_W_SENSE1 3
`define DRW_W_SENSE0 2
`define DRW_W_DIR_HI 1
`define DRW_W_DIR_LO 0
`define DRW_R_ALT_EN 7
`define DRW_R_ALT_FF 6
`define DRW_R_PIN_TIMER 3
`define DRW_R_ROUTE_HI 2
`define DRW_R_ROUTE_LO 0
`define DRW_M_DEST_HI 5
`define DRW_M_DEST_LO 4
`define DRW_M_SRC_HI 3
`define DRW_M_SRC_LO 2
`define DRW_M_TIMING 1
`define DRW_S_RUN 0
`define DRW_S_GUARD_N 1
// ----------------------------------------
// Route codes and timing
// ----------------------------------------
`define DRW_RT_OWN_PIN 3'b000
`define DRW_RT_SERIAL0 3'b001
`define DRW_RT_SERIAL1 3'b010
`define DRW_RT_CH0_PIN 3'b011
`define DRW_CLK_NS 40
`define DRW_MCYCLE_NS 120
`define DRW_BASE_STATES 3'h3
`define DRW_IO_AUTO_WAIT 3'h1
`endif

/* drw_dma_ctrl_sva.sv */
`timescale 1ns/100ps
`include "drw_map.vh"
// --------
// Port checker
// --------
module drw_dma_ctrl_sva
(
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Bus
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	// Sources
	input wire serial0TxReady,
	input wire serial1TxReady,
	input wire serial0RxReady,
	input wire serial1RxReady,
	// Outputs
	input wire [1:0] memoryWaitCount,
	input wire [1:0] ioWaitCount,
	input wire ch1SenseEdge,
	input wire [1:0] ch1DirectionMode,
	input wire ch1Request,
	input wire dmaBusOwn,
	input wire dmaWriteCycle,
	input wire ch0_last_transfer_n
);
	localparam [11:0] AW = {`DRW_IDX_WAIT, 2'b00};
	localparam [11:0] AR = {`DRW_IDX_ROUTE, 2'b00};
	localparam [11:0] AS = {`DRW_IDX_STATE, 2'b00};
	reg [7:0] route_q;
	wire plain = !route_q[7];
	wire [2:0] code = route_q[2:0];
	// Mirror of the route register, so routing is judged from the ports alone.
	always @(posedge mclk)
	begin
		if (rst)
			route_q <= 8'h00;
		else if (psel && penable && pwrite && pstrb[0] && paddr == AR)
			route_q <= pwdata[7:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_wr(a);
		psel && penable && pwrite && pstrb[0] && paddr == a;
	endsequence
	property p_reset_waits;
		$fell(rst) |-> memoryWaitCount == 2'b11 && ioWaitCount == 2'b11;
	endproperty
	a_reset_waits: assert property (p_reset_waits) else $error("waits not ones");
	property p_wait_write;
		s_wr(AW) |=> memoryWaitCount == $past(pwdata[7:6]) && ioWaitCount == $past(pwdata[5:4]);
	endproperty
	a_wait_write: assert property (p_wait_write) else $error("waits not set");
	property p_cfg_write;
		s_wr(AW) |=> ch1SenseEdge == $past(pwdata[3]) && ch1DirectionMode == $past(pwdata[1:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("sense or mode wrong");
	property p_route_tx;
		plain && !ch1DirectionMode[1] && code == 3'b001 |-> ch1Request == serial0TxReady;
	endproperty
	a_route_tx: assert property (p_route_tx) else $error("transmit route wrong");
	property p_route_rx;
		plain && ch1DirectionMode[1] && code == 3'b010 |-> ch1Request == serial1RxReady;
	endproperty
	a_route_rx: assert property (p_route_rx) else $error("receive route wrong");
	property p_route_resv;
		plain && code[2] |-> !ch1Request;
	endproperty
	a_route_resv: assert property (p_route_resv) else $error("reserved route active");
	property p_start;
		s_wr(AS) ##0 (pwdata[1:0] == 2'b01 && !dmaBusOwn) |=> !dmaBusOwn [*3];
	endproperty
	a_start: assert property (p_start) else $error("start too early");
	property p_last;
		!ch0_last_transfer_n |-> dmaWriteCycle && dmaBusOwn;
	endproperty
	a_last: assert property (p_last) else $error("end outside write");
endmodule // drw_dma_ctrl_sva
bind drw_dma_ctrl drw_dma_ctrl_sva drw_dma_ctrl_sva_i (.mclk(mclk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.serial0TxReady(serial0TxReady), .serial1TxReady(serial1TxReady),
	.serial0RxReady(serial0RxReady), .serial1RxReady(serial1RxReady),
	.memoryWaitCount(memoryWaitCount), .ioWaitCount(ioWaitCount), .ch1SenseEdge(ch1SenseEdge),
	.ch1DirectionMode(ch1DirectionMode), .ch1Request(ch1Request), .dmaBusOwn(dmaBusOwn),
	.dmaWriteCycle(dmaWriteCycle), .ch0_last_transfer_n(ch0_last_transfer_n));

/* drw_io_dev.sv */
`timescale 1ns/100ps
// --------
// Requesting device
// --------
module drw_io_dev
(
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Bytes to request
	input wire go,
	input wire [7:0] want,
	// Bus and pin
	input wire dmaWriteCycle,
	output wire reqN
);
	reg [7:0] left_q;
	reg wr_q;
	// Held low until the last requested byte is written; it goes high when the byte count reaches zero.
	always @(posedge mclk)
	begin
		wr_q <= dmaWriteCycle;
		if (rst)
			left_q <= 8'h00;
		else if (go)
			left_q <= want;
		else if (wr_q && !dmaWriteCycle && left_q != 8'h00)
			left_q <= left_q - 8'h01;
	end
	assign reqN = left_q == 8'h00;
endmodule // drw_io_dev

/* dma_request_wait_control_bench.sv */
`timescale 1ns/100ps
`include "drw_map.vh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) fail(g, x); end
module dma_request_wait_control_bench;
	localparam [11:0] aWait = {`DRW_IDX_WAIT, 2'b00};
	localparam [11:0] aRoute = {`DRW_IDX_ROUTE, 2'b00};
	localparam [11:0] aMode = {`DRW_IDX_MODE, 2'b00};
	localparam [11:0] aCount = {`DRW_IDX_COUNT, 2'b00};
	localparam [11:0] aState = {`DRW_IDX_STATE, 2'b00};
	reg mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0;
	reg [3:0] src = 0;
	reg ch1ReqN = 1, ch1End = 0, cpuEnd = 0, devGo = 0;
	reg [7:0] devWant = 0, q = 0;
	integer miscompares = 0, samples_checked = 0, ownCnt, wrEnds, tendAt, lastWr, waitCnt;
	wire [31:0] prdata;
	wire pready, pslverr, ch0ReqN, ch1Req, busOwn, wrC, tendN, done, senseE, timerOut, waitS;
	wire [1:0] memW, ioW, dirM;
	drw_dma_ctrl drw_dma_ctrl_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ch0_request_n(ch0ReqN), .ch1_request_n(ch1ReqN),
		.serial0TxReady(src[0]), .serial1TxReady(src[1]), .serial0RxReady(src[2]),
		.serial1RxReady(src[3]), .ch1TransferEnd(ch1End), .cpuCycleEnd(cpuEnd),
		.memoryWaitCount(memW), .ioWaitCount(ioW), .ch1SenseEdge(senseE),
		.ch1DirectionMode(dirM), .timerPinOut(timerOut), .ch1Request(ch1Req),
		.dmaBusOwn(busOwn), .dmaReadCycle(), .dmaWriteCycle(wrC), .dmaIoAccess(),
		.dmaWaitState(waitS), .ch0_last_transfer_n(tendN), .ch0DonePulse(done));
	drw_io_dev drw_io_dev_i (.mclk(mclk), .rst(rst), .go(devGo), .want(devWant),
		.dmaWriteCycle(wrC), .reqN(ch0ReqN));
	initial
		forever #20 mclk = ~mclk;
	task complete_run;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task fail(input [31:0] g, input [31:0] x);
		miscompares++;
		$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, x);
	endtask
	// The request is held until the edge that samples pready high.
	task bus(input w, input [11:0] a, input [15:0] d);
		integer n;
		n = 0;
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge mclk);
		penable <= 1;
		@(posedge mclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
				fail(0, 1);
			if (n > 20)
				complete_run;
			@(posedge mclk);
		end
		q = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input [11:0] a, input [15:0] d);
		bus(1, a, d);
	endtask
	task dev(input [7:0] n);
		@(posedge mclk);
		devWant <= n;
		devGo <= 1;
		@(posedge mclk);
		devGo <= 0;
	endtask
	task run(input [7:0] w, input [7:0] m, input [15:0] n);
		wr(aWait, {8'h00, w});
		wr(aMode, {8'h00, m});
		wr(aCount, n);
		wr(aState, 16'h0001);
	endtask
	task wait_done;
		integer n;
		n = 0;
		ownCnt = 0;
		wrEnds = 0;
		tendAt = -1;
		lastWr = 0;
		waitCnt = 0;
		while (done !== 1'b1)
		begin
			@(negedge mclk);
			n++;
			if (n > 400)
				fail(0, 1);
			if (n > 400)
				complete_run;
			ownCnt += busOwn;
			waitCnt += waitS;
			if (lastWr && !wrC)
				wrEnds++;
			lastWr = wrC;
			if (tendN === 1'b0 && tendAt < 0)
				tendAt = wrEnds;
		end
	endtask
	task t_regs;
		integer i;
		bus(0, aWait, 0);
		`CHK(q, 8'hf0)
		bus(0, aRoute, 0);
		`CHK(q, 8'h00)
		bus(0, 12'hffc, 0);
		`CHK(e, 1'b1)
		for (i = 0; i < 4; i++)
		begin
			wr(aWait, {8'h00, i[1:0], ~i[1:0], i[0], i[1], ~i[1:0]});
			@(negedge mclk);
			`CHK(memW, i[1:0])
			`CHK(ioW, ~i[1:0])
			`CHK(senseE, i[0])
			`CHK(dirM, ~i[1:0])
		end
		wr(aRoute, 16'h0038);
		bus(0, aRoute, 0);
		`CHK(q, 8'h08)
		`CHK(timerOut, 1'b1)
		wr(aRoute, 16'h0000);
	endtask
	task t_route;
		integer s, c, h;
		for (s = 0; s < 6; s++)
		begin
			src <= (s < 4) ? 4'b0001 << s : 4'h0;
			ch1ReqN <= (s != 4);
			dev((s == 5) ? 8'h01 : 8'h00);
			for (h = 0; h < 2; h++)
				for (c = 0; c < 8; c++)
				begin
					wr(aWait, {14'h0000, h[0], 1'b0});
					wr(aRoute, {13'h0000, c[2:0]});
					@(negedge mclk);
					`CHK(ch1Req, s < 4 ? c == s % 2 + 1 && h == s / 2 : c == (s == 4 ? 0 : 3))
				end
		end
		src <= 4'h0;
		ch1ReqN <= 1;
		dev(8'h00);
	endtask
	task t_alt;
		dev(8'h01);
		wr(aRoute, 16'h0080);
		repeat (3) @(negedge mclk);
		`CHK(ch1Req, 1'b0)
		wr(aRoute, 16'h00c0);
		@(negedge mclk);
		`CHK(ch1Req, 1'b1)
		@(posedge mclk);
		ch1End <= 1;
		@(posedge mclk);
		ch1End <= 0;
		bus(0, aRoute, 0);
		`CHK(q, 8'h80)
		wr(aRoute, 16'h0000);
		dev(8'h00);
	endtask
	task t_burst;
		run(8'h40, 8'h02, 16'h0002);
		repeat (3) @(negedge mclk);
		`CHK(busOwn, 1'b0)
		wait_done;
		`CHK(ownCnt, 16)
		`CHK(waitCnt, 4)
	endtask
	task t_steal;
		run(8'h00, 8'h00, 16'h0002);
		repeat (14) @(negedge mclk);
		`CHK(busOwn, 1'b0)
		@(posedge mclk);
		cpuEnd <= 1;
		@(posedge mclk);
		cpuEnd <= 0;
		wait_done;
		`CHK(ownCnt, 6)
	endtask
	task t_io;
		dev(8'h02);
		run(8'h00, 8'h30, 16'h0002);
		wait_done;
		`CHK(tendAt, 1)
		`CHK(wrEnds, 2)
		`CHK(waitCnt, 2)
		run(8'h04, 8'h30, 16'h0001);
		repeat (10) @(negedge mclk);
		`CHK(busOwn, 1'b0)
		dev(8'h01);
		wait_done;
		`CHK(wrEnds, 1)
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 0;
		t_regs;
		t_route;
		t_alt;
		t_burst;
		t_steal;
		t_io;
		complete_run;
	end
endmodule // dma_request_wait_control_bench
